// [rtl/scg_top.sv]
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Enabled unit gets clock, disabled unit none
// - Access to gated unit returns bus fault
// - Reset clears sleep and deep-sleep registers
// - Run, sleep, deep-sleep gating registers kept
// - Sleep registers apply only with auto-gating
// - Bits 26..24 gate comparators two..zero
// - Bits 18..16 gate timers two..zero
// - Bit 12 gates the I2C unit
// - Bit 4 gates the sync serial unit
// - Bits 1..0 gate UART one and zero
// - Reserved bits read zero, ignore writes
// - Sleep register at offset 0x114
// - Deep-sleep register at 0x124, same layout
// - Run register at 0x104 outside sleep
module scg_top
    import scg_pkg::*;
#(
    parameter int N_UNITS = NUM_UNITS
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire scg_bus_req_t        bus,
    output logic [DATA_W-1:0]        rd_data_reg,
    input  wire scg_pmode_t          pmode,
    input  wire scg_acc_req_t        acc,
    output logic                     acc_fault_reg,
    output logic                     acc_ok_reg,
    output logic [N_UNITS-1:0]       unit_en_reg,
    output logic [N_UNITS-1:0]       unit_clk,
    output logic                     irq_reg
);

    if (N_UNITS != NUM_UNITS) begin : gen_bad_units
        $error("N_UNITS must match the gating word layout");
    end

    logic [DATA_W-1:0] run_gate_ctrl_group1_reg;
    logic [DATA_W-1:0] sleep_gate_ctrl_group1_reg;
    logic [DATA_W-1:0] deepsleep_gate_ctrl_group1_reg;
    logic              auto_gating_select_reg;
    logic [INT_W-1:0]  int_status_reg;
    logic [INT_W-1:0]  int_mask_reg;
    logic [DATA_W-1:0] eff_gate_reg;
    logic [DATA_W-1:0] eff_gate_next;
    logic [N_UNITS-1:0] unit_en_next;
    scg_pmode_t        pmode_prev_reg;
    logic [INT_W-1:0]  int_event;
    logic [DATA_W-1:0] rd_data_next;
    logic              wr_run;
    logic              wr_sleep;
    logic              wr_deep;
    logic              wr_clk_cfg;
    logic              wr_int_stat;
    logic              wr_int_mask;
    logic              fault_pulse;
    logic              ok_pulse;

    always_comb begin
        wr_run      = bus.wr && (bus.addr == OFF_RUN_GATE);
        wr_sleep    = bus.wr && (bus.addr == OFF_SLEEP_GATE);
        wr_deep     = bus.wr && (bus.addr == OFF_DEEP_GATE);
        wr_clk_cfg  = bus.wr && (bus.addr == OFF_RUN_CLK);
        wr_int_stat = bus.wr && (bus.addr == OFF_INT_STAT);
        wr_int_mask = bus.wr && (bus.addr == OFF_INT_MASK);
    end

    // Gating registers, writable bits only
    always_ff @(posedge clk) begin
        if (reset) begin
            run_gate_ctrl_group1_reg <= GATE_RESET;
        end else if (wr_run) begin
            run_gate_ctrl_group1_reg <= bus.wdata & GATE_RW_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sleep_gate_ctrl_group1_reg <= GATE_RESET;
        end else if (wr_sleep) begin
            sleep_gate_ctrl_group1_reg <= bus.wdata & GATE_RW_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            deepsleep_gate_ctrl_group1_reg <= GATE_RESET;
        end else if (wr_deep) begin
            deepsleep_gate_ctrl_group1_reg <= bus.wdata & GATE_RW_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            auto_gating_select_reg <= 1'b0;
        end else if (wr_clk_cfg) begin
            auto_gating_select_reg <= bus.wdata[BIT_AUTO_GATE];
        end
    end

    // Pick the register set for the present power mode
    always_comb begin
        case (pmode)
            SCG_PM_RUN: begin
                eff_gate_next = run_gate_ctrl_group1_reg;
            end
            SCG_PM_SLEEP: begin
                eff_gate_next = auto_gating_select_reg
                              ? sleep_gate_ctrl_group1_reg
                              : run_gate_ctrl_group1_reg;
            end
            SCG_PM_DEEP: begin
                eff_gate_next = auto_gating_select_reg
                              ? deepsleep_gate_ctrl_group1_reg
                              : run_gate_ctrl_group1_reg;
            end
            default: begin
                eff_gate_next = run_gate_ctrl_group1_reg;
            end
        endcase
    end

    // Fan the gating word out to one enable per unit
    always_comb begin
        for (int i = 0; i < N_UNITS; i++) begin
            unit_en_next[i] = eff_gate_next[scg_unit_bit(i)];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            eff_gate_reg <= GATE_RESET;
            unit_en_reg  <= '0;
        end else begin
            eff_gate_reg <= eff_gate_next;
            unit_en_reg  <= unit_en_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_UNITS; g++) begin : gen_gate
            scg_clock_gate u_gate (
                .clk       (clk),
                .enable    (unit_en_reg[g]),
                .gated_clk (unit_clk[g])
            );
        end
    endgenerate

    scg_access_check #(
        .N_UNITS (N_UNITS)
    ) u_check (
        .clk       (clk),
        .reset     (reset),
        .acc       (acc),
        .unit_en   (unit_en_reg),
        .fault_reg (fault_pulse),
        .ok_reg    (ok_pulse)
    );

    always_comb begin
        acc_fault_reg = fault_pulse;
        acc_ok_reg    = ok_pulse;
    end

    // Events: fault, entry to sleep, entry to deep sleep
    always_ff @(posedge clk) begin
        if (reset) begin
            pmode_prev_reg <= SCG_PM_RUN;
        end else begin
            pmode_prev_reg <= pmode;
        end
    end

    always_comb begin
        int_event               = '0;
        int_event[INT_FAULT]    = fault_pulse;
        int_event[INT_SLEEP_IN] = (pmode == SCG_PM_SLEEP)
                               && (pmode_prev_reg != SCG_PM_SLEEP);
        int_event[INT_DEEP_IN]  = (pmode == SCG_PM_DEEP)
                               && (pmode_prev_reg != SCG_PM_DEEP);
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk) begin
        if (reset) begin
            int_status_reg <= INT_RESET;
        end else if (wr_int_stat) begin
            int_status_reg <= (int_status_reg & ~bus.wdata[INT_W-1:0]) | int_event;
        end else begin
            int_status_reg <= int_status_reg | int_event;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            int_mask_reg <= INT_RESET;
        end else if (wr_int_mask) begin
            int_mask_reg <= bus.wdata[INT_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(int_status_reg & int_mask_reg);
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_data_next = WORD_ZERO;
        case (bus.addr)
            OFF_RUN_GATE:   rd_data_next = run_gate_ctrl_group1_reg;
            OFF_SLEEP_GATE: rd_data_next = sleep_gate_ctrl_group1_reg;
            OFF_DEEP_GATE:  rd_data_next = deepsleep_gate_ctrl_group1_reg;
            OFF_RUN_CLK: begin
                rd_data_next[BIT_AUTO_GATE] = auto_gating_select_reg;
            end
            OFF_INT_STAT: begin
                rd_data_next[INT_W-1:0] = int_status_reg;
            end
            OFF_INT_MASK: begin
                rd_data_next[INT_W-1:0] = int_mask_reg;
            end
            OFF_EFF_GATE:   rd_data_next = eff_gate_reg;
            default:        rd_data_next = WORD_ZERO;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data_reg <= WORD_ZERO;
        end else if (bus.rd) begin
            rd_data_reg <= rd_data_next;
        end else begin
            rd_data_reg <= WORD_ZERO;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic past_valid_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            past_valid_reg <= 1'b0;
        end else begin
            past_valid_reg <= 1'b1;
        end
    end

    AST_RESET_CLEAR: assert property (
        @(posedge clk) disable iff (1'b0)
        reset |=> sleep_gate_ctrl_group1_reg == GATE_RESET
              && deepsleep_gate_ctrl_group1_reg == GATE_RESET
              && unit_en_reg == '0)
        else $error("gating registers not cleared by reset");

    AST_RESERVED_ZERO: assert property (
        ((sleep_gate_ctrl_group1_reg | deepsleep_gate_ctrl_group1_reg
          | run_gate_ctrl_group1_reg) & ~GATE_RW_MASK) == WORD_ZERO)
        else $error("reserved gating bit set");

    AST_SLEEP_WRITE: assert property (
        bus.wr && bus.addr == 12'h114
        |=> sleep_gate_ctrl_group1_reg == ($past(bus.wdata) & 32'h0707_1013))
        else $error("sleep register write not taken");

    AST_DEEP_WRITE: assert property (
        bus.wr && bus.addr == 12'h124
        |=> deepsleep_gate_ctrl_group1_reg == ($past(bus.wdata) & 32'h0707_1013))
        else $error("deep-sleep register write not taken");

    AST_RUN_WRITE: assert property (
        bus.wr && bus.addr == 12'h104
        |=> run_gate_ctrl_group1_reg == ($past(bus.wdata) & 32'h0707_1013))
        else $error("run register write not taken");

    AST_NO_AUTO_RUN: assert property (
        past_valid_reg && !auto_gating_select_reg && !wr_run
        |=> eff_gate_reg == $past(run_gate_ctrl_group1_reg))
        else $error("sleep set applied without auto-gating");

    AST_DEEP_SELECT: assert property (
        auto_gating_select_reg && pmode == SCG_PM_DEEP
        |=> eff_gate_reg == $past(deepsleep_gate_ctrl_group1_reg))
        else $error("deep-sleep set not applied");

    AST_SLEEP_SELECT: assert property (
        auto_gating_select_reg && pmode == SCG_PM_SLEEP
        |=> eff_gate_reg == $past(sleep_gate_ctrl_group1_reg))
        else $error("sleep set not applied");

    // Read data returns to zero outside the answer cycle
    AST_READ_IDLE_ZERO: assert property (
        !bus.rd |=> rd_data_reg == WORD_ZERO)
        else $error("read data outside its cycle");

    AST_BIT_MAP: assert property (
        unit_en_reg[7] == eff_gate_reg[24] && unit_en_reg[9] == eff_gate_reg[26]
        && unit_en_reg[4] == eff_gate_reg[16] && unit_en_reg[3] == eff_gate_reg[12]
        && unit_en_reg[2] == eff_gate_reg[4] && unit_en_reg[1] == eff_gate_reg[1]
        && unit_en_reg[0] == eff_gate_reg[0] && unit_en_reg[5] == eff_gate_reg[17]
        && unit_en_reg[6] == eff_gate_reg[18] && unit_en_reg[8] == eff_gate_reg[25])
        else $error("unit enable does not follow its bit");

    AST_FAULT_GATED: assert property (
        acc.valid && int'(acc.unit) < N_UNITS && !unit_en_reg[acc.unit]
        |=> acc_fault_reg && !acc_ok_reg)
        else $error("access to gated unit not faulted");

    AST_OK_ENABLED: assert property (
        acc.valid && int'(acc.unit) < N_UNITS && unit_en_reg[acc.unit]
        |=> acc_ok_reg && !acc_fault_reg)
        else $error("access to enabled unit faulted");

    AST_READ_ONE_CYCLE: assert property (
        bus.rd && bus.addr == 12'h114
        |=> rd_data_reg == $past(sleep_gate_ctrl_group1_reg))
        else $error("sleep register read wrong");

    AST_IRQ_LEVEL: assert property (
        past_valid_reg |-> irq_reg == |($past(int_status_reg) & $past(int_mask_reg)))
        else $error("interrupt level wrong");

    COV_SLEEP_AUTO: cover property (
        auto_gating_select_reg && pmode == SCG_PM_SLEEP ##1 unit_en_reg != '0);

    COV_FAULT: cover property (acc.valid ##1 acc_fault_reg ##1 irq_reg);

    COV_ENABLE_ACCESS: cover property (wr_run ##2 acc.valid ##1 acc_ok_reg);

endmodule

`default_nettype wire

// [rtl/scg_pkg.sv]
package scg_pkg;

    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int NUM_UNITS = 10;
    localparam int UNIT_W    = 4;
    localparam int INT_W     = 3;

    localparam logic [ADDR_W-1:0] OFF_RUN_GATE   = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_SLEEP_GATE = 12'h114;
    localparam logic [ADDR_W-1:0] OFF_DEEP_GATE  = 12'h124;
    localparam logic [ADDR_W-1:0] OFF_RUN_CLK    = 12'h130;
    localparam logic [ADDR_W-1:0] OFF_INT_STAT   = 12'h134;
    localparam logic [ADDR_W-1:0] OFF_INT_MASK   = 12'h138;
    localparam logic [ADDR_W-1:0] OFF_EFF_GATE   = 12'h13C;

    localparam int BIT_UART_ZERO   = 0;
    localparam int BIT_UART_ONE    = 1;
    localparam int BIT_SYNC_SERIAL = 4;
    localparam int BIT_I2C_ZERO    = 12;
    localparam int BIT_TMR0  = 16;
    localparam int BIT_TMR1  = 17;
    localparam int BIT_TMR2  = 18;
    localparam int BIT_CMP0  = 24;
    localparam int BIT_CMP1  = 25;
    localparam int BIT_CMP2  = 26;

    localparam logic [DATA_W-1:0] GATE_RW_MASK = 32'h0707_1013;
    localparam logic [DATA_W-1:0] GATE_RESET   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] WORD_ZERO    = 32'h0000_0000;
    localparam int                BIT_AUTO_GATE = 0;

    localparam int INT_FAULT     = 0;
    localparam int INT_SLEEP_IN  = 1;
    localparam int INT_DEEP_IN   = 2;
    localparam logic [INT_W-1:0] INT_RESET = 3'h0;

    typedef enum logic [1:0] {
        SCG_PM_RUN,
        SCG_PM_SLEEP,
        SCG_PM_DEEP
    } scg_pmode_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } scg_bus_req_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [UNIT_W-1:0] unit;
    } scg_acc_req_t;

    // Unit index to its bit in a gating word
    function automatic int scg_unit_bit(input int idx);
        case (idx)
            0:       return BIT_UART_ZERO;
            1:       return BIT_UART_ONE;
            2:       return BIT_SYNC_SERIAL;
            3:       return BIT_I2C_ZERO;
            4:       return BIT_TMR0;
            5:       return BIT_TMR1;
            6:       return BIT_TMR2;
            7:       return BIT_CMP0;
            8:       return BIT_CMP1;
            default: return BIT_CMP2;
        endcase
    endfunction

endpackage

// [rtl/scg_clock_gate.sv]
`timescale 1ns/10ps
`default_nettype none

// Enable caught while clk is low, so the AND never slices a high phase
module scg_clock_gate (
    input  wire logic clk,
    input  wire logic enable,
    output logic      gated_clk
);

    logic en_latch;

    always_latch begin
        if (!clk) begin
            en_latch <= enable;
        end
    end

    assign gated_clk = clk & en_latch;

endmodule

`default_nettype wire

// [rtl/scg_access_check.sv]
`timescale 1ns/10ps
`default_nettype none

module scg_access_check
    import scg_pkg::*;
#(
    parameter int N_UNITS = NUM_UNITS
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire scg_acc_req_t        acc,
    input  wire logic [N_UNITS-1:0]  unit_en,
    output logic                     fault_reg,
    output logic                     ok_reg
);

    if (N_UNITS < 1 || N_UNITS > (1 << UNIT_W)) begin : gen_bad_units
        $error("N_UNITS out of range");
    end

    logic known;
    logic enabled;

    always_comb begin
        known   = (int'(acc.unit) < N_UNITS);
        enabled = known && unit_en[acc.unit];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fault_reg <= 1'b0;
            ok_reg    <= 1'b0;
        end else begin
            fault_reg <= acc.valid && !enabled;
            ok_reg    <= acc.valid && enabled;
        end
    end

endmodule

`default_nettype wire

// [tb/scg_periph_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Power-mode controller and the gated peripherals behind the block
module scg_periph_model
    import scg_pkg::*;
#(
    parameter int N_UNITS = NUM_UNITS
) (
    input  wire logic               clk,
    input  wire logic [N_UNITS-1:0] unit_clk,
    input  wire logic               acc_fault_reg,
    input  wire logic               acc_ok_reg,
    output var  scg_pmode_t         pmode,
    output var  scg_acc_req_t       acc
);
    wire [31:0] cnt_w [N_UNITS];

    initial begin
        pmode = SCG_PM_RUN;
        acc   = '0;
    end

    for (genvar g = 0; g < N_UNITS; g++) begin : g_unit
        int unsigned edge_cnt = 0;
        // A unit only advances on the clock it really receives
        always @(posedge unit_clk[g]) begin
            edge_cnt <= edge_cnt + 1;
        end
        assign cnt_w[g] = edge_cnt;
    end

    task automatic set_mode(input scg_pmode_t m);
        @(posedge clk);
        pmode <= m;
    endtask

    // Answer stands only in the cycle after the access is taken
    task automatic access(input int unit, input logic wr, output logic flt, output logic ok);
        @(posedge clk);
        acc <= '{valid: 1'b1, write: wr, unit: UNIT_W'(unit)};
        @(posedge clk);
        acc <= '{valid: 1'b0, write: ~wr, unit: ~UNIT_W'(unit)};
        @(negedge clk);
        flt = acc_fault_reg;
        ok  = acc_ok_reg;
    endtask
endmodule

`default_nettype wire

// [tb/scg_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module scg_top_tb
    import scg_pkg::*;
;
    localparam int UBIT [NUM_UNITS] = '{0, 1, 4, 12, 16, 17, 18, 24, 25, 26};

    logic                 clk;
    logic                 reset;
    scg_bus_req_t         bus;
    logic [DATA_W-1:0]    rd_data_reg;
    scg_pmode_t           pmode;
    scg_acc_req_t         acc;
    logic                 acc_fault_reg;
    logic                 acc_ok_reg;
    logic [NUM_UNITS-1:0] unit_en_reg;
    logic [NUM_UNITS-1:0] unit_clk;
    logic                 irq_reg;
    int                   n_errors;
    int                   n_compared;

    scg_top #(.N_UNITS(NUM_UNITS)) dut (
        .clk(clk), .reset(reset), .bus(bus), .rd_data_reg(rd_data_reg), .pmode(pmode),
        .acc(acc), .acc_fault_reg(acc_fault_reg), .acc_ok_reg(acc_ok_reg),
        .unit_en_reg(unit_en_reg), .unit_clk(unit_clk), .irq_reg(irq_reg)
    );

    scg_periph_model #(.N_UNITS(NUM_UNITS)) model (
        .clk(clk), .unit_clk(unit_clk), .acc_fault_reg(acc_fault_reg),
        .acc_ok_reg(acc_ok_reg), .pmode(pmode), .acc(acc)
    );

    always #50 clk = ~clk;

    task automatic give_verdict;
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_flag(input string name, input logic exp, input logic got);
        chk_word(name, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: WORD_ZERO};
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: WORD_ZERO};
        @(negedge clk);
        d = rd_data_reg;
    endtask

    task automatic chk_reg(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [DATA_W-1:0] d;
        rd_reg(a, d);
        chk_word(name, e, d);
    endtask

    // Enable follows a register or mode change one edge later
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic chk_en(input logic [31:0] e);
        settle();
        chk_word("unit_en_reg", e, 32'(unit_en_reg));
    endtask

    task automatic chk_clocks(input int i, input int unsigned exp_n);
        int unsigned c0;
        @(negedge clk);
        c0 = model.cnt_w[i];
        repeat (4) @(negedge clk);
        chk_word("unit_clk_edges", 32'(exp_n), model.cnt_w[i] - c0);
    endtask

    task automatic chk_acc(input int unit, input logic exp_fault);
        logic f;
        logic o;
        model.access(unit, unit[0], f, o);
        chk_flag("acc_fault_reg", exp_fault, f);
        chk_flag("acc_ok_reg", ~exp_fault, o);
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        n_errors++;
        $display("Error run_length expected finish seen timeout");
        give_verdict();
    end

    initial begin
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] mask;
        clk = 1'b0;
        reset = 1'b1;
        bus = '0;
        n_errors = 0;
        n_compared = 0;
        mask = '0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        chk_reg("run_gate", OFF_RUN_GATE, 32'h0000_0000);
        chk_reg("sleep_gate", OFF_SLEEP_GATE, 32'h0000_0000);
        chk_reg("deep_gate", OFF_DEEP_GATE, 32'h0000_0000);
        chk_acc(0, 1'b1);
        for (int i = 0; i < NUM_UNITS; i++) begin
            mask[UBIT[i]] = 1'b1;
        end
        wr_reg(OFF_SLEEP_GATE, 32'hFFFF_FFFF);
        wr_reg(OFF_DEEP_GATE, 32'hFFFF_FFFF);
        chk_reg("sleep_gate", OFF_SLEEP_GATE, mask);
        chk_reg("deep_gate", OFF_DEEP_GATE, mask);
        rd_reg(OFF_DEEP_GATE, d);
        wr_reg(OFF_DEEP_GATE, d & ~32'h0000_0001);
        chk_reg("deep_gate", OFF_DEEP_GATE, mask & ~32'h0000_0001);
        wr_reg(12'h200, 32'hFFFF_FFFF);
        chk_reg("unmapped", 12'h200, 32'h0000_0000);
        chk_reg("run_gate", OFF_RUN_GATE, 32'h0000_0000);
        for (int i = 0; i < NUM_UNITS; i++) begin
            wr_reg(OFF_RUN_GATE, 32'h1 << UBIT[i]);
            chk_en(32'h1 << i);
            chk_clocks(i, 4);
            chk_clocks((i + 1) % NUM_UNITS, 0);
            chk_acc(i, 1'b0);
            chk_acc((i + 1) % NUM_UNITS, 1'b1);
        end
        chk_acc(15, 1'b1);
        wr_reg(OFF_INT_STAT, 32'h0000_0007);
        wr_reg(OFF_INT_MASK, 32'h0000_0001);
        chk_acc(3, 1'b1);
        settle();
        chk_flag("irq_reg", 1'b1, irq_reg);
        wr_reg(OFF_INT_STAT, 32'h0000_0001);
        settle();
        chk_flag("irq_reg", 1'b0, irq_reg);
        wr_reg(OFF_INT_MASK, 32'h0000_0000);
        chk_acc(3, 1'b1);
        settle();
        chk_flag("irq_reg", 1'b0, irq_reg);
        wr_reg(OFF_INT_STAT, 32'h0000_0007);
        wr_reg(OFF_RUN_GATE, 32'h1 << UBIT[0]);
        wr_reg(OFF_SLEEP_GATE, 32'h1 << UBIT[4]);
        wr_reg(OFF_DEEP_GATE, 32'h1 << UBIT[9]);
        model.set_mode(SCG_PM_SLEEP);
        chk_en(32'h1);
        wr_reg(OFF_RUN_CLK, 32'h1 << BIT_AUTO_GATE);
        chk_en(32'h1 << 4);
        chk_acc(0, 1'b1);
        model.set_mode(SCG_PM_DEEP);
        chk_en(32'h1 << 9);
        chk_clocks(9, 4);
        chk_reg("eff_gate", OFF_EFF_GATE, 32'h1 << UBIT[9]);
        model.set_mode(SCG_PM_RUN);
        chk_en(32'h1);
        chk_reg("int_stat", OFF_INT_STAT, 32'h0000_0007);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        chk_reg("run_gate", OFF_RUN_GATE, 32'h0000_0000);
        chk_reg("sleep_gate", OFF_SLEEP_GATE, 32'h0000_0000);
        chk_reg("deep_gate", OFF_DEEP_GATE, 32'h0000_0000);
        chk_en(32'h0);
        give_verdict();
    end
endmodule

`default_nettype wire
